/* rtl/cepc_pkg.sv */
// Package with constants and types for the cyclic edge position capture block
package cepc_pkg;

  // Data and counter widths
  localparam int unsigned POS_W          = 32;
  localparam int unsigned LOST_W         = 16;
  localparam int unsigned ACQ_W          = 32;
  localparam int unsigned ADDR_W         = 8;

  // Clock and position control cycle timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SERVO_US       = 1000;
  localparam int unsigned SERVO_CYC      = (CLK_HZ / 1_000_000) * SERVO_US;
  localparam int unsigned PERIOD_MIN     = 4;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_PERIOD     = 8'h04;
  localparam logic [7:0]  OFS_SLOT_ONE   = 8'h08;
  localparam logic [7:0]  OFS_SLOT_TWO   = 8'h0c;
  localparam logic [7:0]  OFS_LOST_ONE   = 8'h10;
  localparam logic [7:0]  OFS_LOST_TWO   = 8'h14;
  localparam logic [7:0]  OFS_ACQ_ONE    = 8'h18;
  localparam logic [7:0]  OFS_ACQ_TWO    = 8'h1c;
  localparam logic [7:0]  OFS_STATUS     = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_LO   = 1;
  localparam int unsigned CTRL_MODE_HI   = 2;

  // Status field positions
  localparam int unsigned STAT_IN_BIT    = 0;
  localparam int unsigned STAT_RUN_BIT   = 1;

  // Reset values
  localparam logic        RST_EN         = 1'b0;
  localparam logic [1:0]  RST_MODE       = 2'h0;

  // Edge selection of the cyclic measure command
  typedef enum logic [1:0] {
    CEPC_MODE_POS  = 2'h0,
    CEPC_MODE_NEG  = 2'h1,
    CEPC_MODE_BOTH = 2'h2
  } cepc_mode_e;

  // Results published at each cycle end
  typedef struct packed {
    logic [POS_W-1:0]  slot_one;
    logic [POS_W-1:0]  slot_two;
    logic [LOST_W-1:0] lost_one;
    logic [LOST_W-1:0] lost_two;
    logic [ACQ_W-1:0]  acq_one;
    logic [ACQ_W-1:0]  acq_two;
  } cepc_result_s;

  // Edge events of the measuring input
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } cepc_edge_s;

endpackage : cepc_pkg

/* rtl/cepc_sync.sv */
// Three-stage synchroniser and edge detector for the measuring input pin
`timescale 1ns/10ps

module cepc_sync (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pin_in,
  output cepc_pkg::cepc_edge_s  edge_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  always_comb begin
    edge_o.level = level_q;
    edge_o.rise  = (s2_q == s3_q) && s3_q && !level_q;
    edge_o.fall  = (s2_q == s3_q) && !s3_q && level_q;
  end

endmodule : cepc_sync

/* rtl/cepc_top.sv */
// Cyclic edge position capture with APB register access
// How it works
// - Mode 0: first rising edge to slot one, second rising to slot two.
// - Mode 1: first falling edge to slot one, second falling to slot two.
// - Mode 2: first rising edge to slot one, first falling edge to slot two.
// - Lost counts report selected edges of the cycle beyond the two used.
// - Both slots filled in a cycle: both lost counts show the same value.
// - Only slot one filled: lost count one cleared, lost count two kept.
// - Both-edge mode, only slot two filled: lost two cleared, one kept.
// - Each slot has its own acquisition count, bumped on every new value.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps

module cepc_top #(
  parameter int unsigned SERVO_CYCLES = cepc_pkg::SERVO_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cepc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        measure_in,
  input  wire logic [cepc_pkg::POS_W-1:0]  axis_position,
  output logic                             cycle_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cepc_pkg::cepc_edge_s   edge_s;
  cepc_pkg::cepc_result_s res_q;
  cepc_pkg::cepc_mode_e   mode_q;

  logic                          enable_q;
  logic [31:0]                   period_q;
  logic [31:0]                   tick_cnt_q;
  logic                          tick;
  logic                          cycle_done_q;

  logic                          got_one_q;
  logic                          got_two_q;
  logic [cepc_pkg::POS_W-1:0]    val_one_q;
  logic [cepc_pkg::POS_W-1:0]    val_two_q;
  logic [cepc_pkg::LOST_W-1:0]   edges_q;

  logic                          got_one_d;
  logic                          got_two_d;
  logic [cepc_pkg::POS_W-1:0]    val_one_d;
  logic [cepc_pkg::POS_W-1:0]    val_two_d;
  logic [cepc_pkg::LOST_W-1:0]   edges_d;
  logic [cepc_pkg::LOST_W-1:0]   excess;
  logic                          sel_edge;

  logic                          setup;
  logic                          access;
  logic                          wr_en;
  logic                          pready_q;
  logic                          pslverr_q;
  logic [31:0]                   prdata_q;
  logic [31:0]                   rd_data;
  logic                          rd_hit;
  logic                          wr_ctrl;
  logic                          wr_period;

  ////////////////////////////////////////////////////////////////////////////
  // Measuring input synchroniser

  cepc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (measure_in),
    .edge_o  (edge_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Position control cycle divider

  assign tick = enable_q && (tick_cnt_q >= period_q - 32'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else if (!enable_q || tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_done_q <= 1'b0;
    end else begin
      cycle_done_q <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge evaluation within the running cycle

  always_comb begin
    got_one_d = got_one_q;
    got_two_d = got_two_q;
    val_one_d = val_one_q;
    val_two_d = val_two_q;
    sel_edge  = 1'b0;
    case (mode_q)
      cepc_pkg::CEPC_MODE_POS: begin
        sel_edge = edge_s.rise;
      end
      cepc_pkg::CEPC_MODE_NEG: begin
        sel_edge = edge_s.fall;
      end
      default: begin
        sel_edge = edge_s.rise || edge_s.fall;
      end
    endcase
    if (mode_q == cepc_pkg::CEPC_MODE_BOTH) begin
      if (edge_s.rise && !got_one_q) begin
        got_one_d = 1'b1;
        val_one_d = axis_position;
      end
      if (edge_s.fall && !got_two_q) begin
        got_two_d = 1'b1;
        val_two_d = axis_position;
      end
    end else if (sel_edge) begin
      if (!got_one_q) begin
        got_one_d = 1'b1;
        val_one_d = axis_position;
      end else if (!got_two_q) begin
        got_two_d = 1'b1;
        val_two_d = axis_position;
      end
    end
    // Saturate so a chattering input cannot wrap the count
    if (sel_edge && (edges_q != {cepc_pkg::LOST_W{1'b1}})) begin
      edges_d = edges_q + 16'h1;
    end else begin
      edges_d = edges_q;
    end
    if (edges_d > 16'h2) begin
      excess = edges_d - 16'h2;
    end else begin
      excess = 16'h0;
    end
  end

  // Edge landing on the tick belongs to the ending cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_one_q <= 1'b0;
      got_two_q <= 1'b0;
      val_one_q <= '0;
      val_two_q <= '0;
      edges_q   <= '0;
    end else if (!enable_q || tick) begin
      got_one_q <= 1'b0;
      got_two_q <= 1'b0;
      val_one_q <= '0;
      val_two_q <= '0;
      edges_q   <= '0;
    end else begin
      got_one_q <= got_one_d;
      got_two_q <= got_two_d;
      val_one_q <= val_one_d;
      val_two_q <= val_two_d;
      edges_q   <= edges_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit of results at cycle end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
    end else if (tick) begin
      if (got_one_d) begin
        res_q.slot_one <= val_one_d;
        res_q.acq_one  <= res_q.acq_one + 32'h1;
      end
      if (got_two_d) begin
        res_q.slot_two <= val_two_d;
        res_q.acq_two  <= res_q.acq_two + 32'h1;
      end
      if (got_one_d && got_two_d) begin
        res_q.lost_one <= excess;
        res_q.lost_two <= excess;
      end else if (got_one_d) begin
        res_q.lost_one <= 16'h0;
      end else if (got_two_d) begin
        res_q.lost_two <= 16'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, read data captured in setup

  assign setup  = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_en  = access && pwrite && !pslverr_q;

  always_comb begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    if (paddr == cepc_pkg::OFS_CTRL) begin
      rd_data[cepc_pkg::CTRL_EN_BIT]                         = enable_q;
      rd_data[cepc_pkg::CTRL_MODE_HI:cepc_pkg::CTRL_MODE_LO] = mode_q;
    end else if (paddr == cepc_pkg::OFS_PERIOD) begin
      rd_data = period_q;
    end else if (paddr == cepc_pkg::OFS_SLOT_ONE) begin
      rd_data = res_q.slot_one;
    end else if (paddr == cepc_pkg::OFS_SLOT_TWO) begin
      rd_data = res_q.slot_two;
    end else if (paddr == cepc_pkg::OFS_LOST_ONE) begin
      rd_data = {16'h0, res_q.lost_one};
    end else if (paddr == cepc_pkg::OFS_LOST_TWO) begin
      rd_data = {16'h0, res_q.lost_two};
    end else if (paddr == cepc_pkg::OFS_ACQ_ONE) begin
      rd_data = res_q.acq_one;
    end else if (paddr == cepc_pkg::OFS_ACQ_TWO) begin
      rd_data = res_q.acq_two;
    end else if (paddr == cepc_pkg::OFS_STATUS) begin
      rd_data[cepc_pkg::STAT_IN_BIT]  = edge_s.level;
      rd_data[cepc_pkg::STAT_RUN_BIT] = enable_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !rd_hit;
      prdata_q  <= pwrite ? 32'h0 : rd_data;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  // Read-only offsets decode to nothing, so their writes fall away silently
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_period = 1'b0;
    if (!wr_en) begin
      wr_ctrl   = 1'b0;
    end else if (paddr == cepc_pkg::OFS_CTRL) begin
      wr_ctrl   = 1'b1;
    end else if (paddr == cepc_pkg::OFS_PERIOD) begin
      wr_period = 1'b1;
    end
  end

  // A reserved mode 3 in a write is dropped and the old mode kept; the enable bit is still written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= cepc_pkg::RST_EN;
      mode_q   <= cepc_pkg::cepc_mode_e'(cepc_pkg::RST_MODE);
    end else if (wr_ctrl) begin
      enable_q <= pwdata[cepc_pkg::CTRL_EN_BIT];
      if (pwdata[cepc_pkg::CTRL_MODE_HI:cepc_pkg::CTRL_MODE_LO] != 2'h3) begin
        mode_q <= cepc_pkg::cepc_mode_e'(pwdata[cepc_pkg::CTRL_MODE_HI:cepc_pkg::CTRL_MODE_LO]);
      end
    end
  end

  // Too short a cycle would leave no room for two edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= SERVO_CYCLES;
    end else if (wr_period) begin
      if (pwdata < cepc_pkg::PERIOD_MIN) begin
        period_q <= cepc_pkg::PERIOD_MIN;
      end else begin
        period_q <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign cycle_done = cycle_done_q;

endmodule : cepc_top

/* tb/cepc_monitor.sv */
// Checker on the APB port and cycle pulse of the capture block
`timescale 1ns/10ps

module cepc_monitor #(
  parameter int unsigned SERVO_CYCLES = 20
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [cepc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        cycle_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  property p_ready_answer;
    psel && !penable |=> pready && psel && penable;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("pready missing after setup");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("pready held too long");
  property p_ready_cause;
    pready |-> $past(psel && !penable) && penable;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_err_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h20);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_lost_narrow;
    pready && !pwrite && (paddr == cepc_pkg::OFS_LOST_ONE || paddr == cepc_pkg::OFS_LOST_TWO)
      |-> prdata[31:16] == 16'h0;
  endproperty
  a_lost_narrow: assert property (p_lost_narrow) else $error("lost count upper bits set");
  // Period never below four, so a pulse needs three quiet cycles after it
  property p_done_gap;
    cycle_done |=> !cycle_done [*3];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("cycle pulses too close");
endmodule : cepc_monitor

bind cepc_top cepc_monitor #(.SERVO_CYCLES(SERVO_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_done(cycle_done)
);

/* tb/cepc_pin_model.sv */
// Model of the measuring pin and the axis position source
`timescale 1ns/10ps

module cepc_pin_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin_req,
  input  wire logic [31:0] pos_req,
  output logic             measure_in,
  output logic [31:0]      axis_position
);
  // Pin follows its command one edge late, like a slow external source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      measure_in    <= 1'b0;
      axis_position <= 32'h0;
    end else begin
      measure_in    <= pin_req;
      axis_position <= pos_req;
    end
  end
endmodule : cepc_pin_model

/* tb/cyclic_edge_position_capture_tb.sv */
// Self-checking bench for the cyclic edge position capture block
`timescale 1ns/10ps

module cyclic_edge_position_capture_tb;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_done;
  logic                        pin_req, measure_in, err, lvl;
  logic [cepc_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                 pwdata, prdata, pos_req, axis_position, rd;
  logic [31:0]                 ex [6];
  logic                        rq [$];
  logic [31:0]                 pq [$];
  int                          n_mismatch, cmp_count, seed, ne;

  cepc_top #(.SERVO_CYCLES(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .measure_in(measure_in),
    .axis_position(axis_position), .cycle_done(cycle_done)
  );
  cepc_pin_model u_pin (
    .pclk(pclk), .presetn(presetn), .pin_req(pin_req), .pos_req(pos_req),
    .measure_in(measure_in), .axis_position(axis_position)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task conclude;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_done;
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (cycle_done !== 1'b1 && k < 400);
    if (k >= 400) begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_done

  // Position held eight cycles so the sync delay cannot pick a stale value
  task edge_ev;
    logic [31:0] v;
    lvl = ~lvl;
    v = $random(seed);
    pin_req <= lvl;
    pos_req <= v;
    rq.push_back(lvl);
    pq.push_back(v);
    repeat (8) @(posedge pclk);
  endtask : edge_ev

  // Reference of one control cycle from the recorded pin events
  task model(input int md);
    int n;
    logic n1, n2;
    n = 0;
    n1 = 1'b0;
    n2 = 1'b0;
    foreach (rq[i]) if (md == 2 || rq[i] == (md == 0)) begin
      n++;
      if (md == 2 ? (rq[i] && !n1) : n == 1) begin
        ex[0] = pq[i];
        n1 = 1'b1;
      end else if (md == 2 ? (!rq[i] && !n2) : n == 2) begin
        ex[1] = pq[i];
        n2 = 1'b1;
      end
    end
    n = n > 2 ? n - 2 : 0;
    if (n1 && n2) begin
      ex[2] = 32'(n);
      ex[3] = 32'(n);
    end else if (n1) ex[2] = 32'h0;
    else if (n2) ex[3] = 32'h0;
    ex[4] = ex[4] + 32'(n1);
    ex[5] = ex[5] + 32'(n2);
    rq.delete();
    pq.delete();
  endtask : model
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5c0d;
    n_mismatch = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, pin_req, lvl} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pos_req = 32'h0;
    foreach (ex[i]) ex[i] = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cepc_pkg::OFS_PERIOD, 32'h0);
    check(rd, 32'h14);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, cepc_pkg::OFS_ACQ_ONE, 32'h5);
    check({31'h0, err}, 32'h0);
    apb(1'b1, cepc_pkg::OFS_PERIOD, 32'h2);
    apb(1'b0, cepc_pkg::OFS_PERIOD, 32'h0);
    check(rd, 32'(cepc_pkg::PERIOD_MIN));
    apb(1'b1, cepc_pkg::OFS_PERIOD, 32'h64);
    apb(1'b0, cepc_pkg::OFS_PERIOD, 32'h0);
    check(rd, 32'h64);
    for (int md = 0; md < 3; md++) begin
      apb(1'b1, cepc_pkg::OFS_CTRL, 32'h0);
      rq.delete();
      pq.delete();
      apb(1'b1, cepc_pkg::OFS_CTRL, 32'(md * 2 + 1));
      apb(1'b1, cepc_pkg::OFS_CTRL, 32'h7);
      apb(1'b0, cepc_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'(md * 2 + 1));
      apb(1'b0, cepc_pkg::OFS_STATUS, 32'h0);
      check(rd, {30'h0, 1'b1, lvl});
      repeat (8) begin
        wait_done();
        model(md);
        for (int i = 0; i < 6; i++) begin
          apb(1'b0, cepc_pkg::OFS_SLOT_ONE + 8'(i * 4), 32'h0);
          check(rd, ex[i]);
        end
        ne = {$random(seed)} % 7;
        repeat (ne) edge_ev();
      end
    end
    conclude();
  end
endmodule : cyclic_edge_position_capture_tb
